/* File: design/tim_chan.sv */
`include "tim_chan_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module tim_chan (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // Shared timer counter
  input  wire logic [15:0] i_count,
  input  wire logic        i_overflow,
  // Channel pins and port fallback
  input  wire logic [5:0]  i_pin_in,
  input  wire logic [5:0]  i_port_data,
  input  wire logic [5:0]  i_port_dir,
  output logic [5:0]       o_pin_out,
  output logic [5:0]       o_pin_oe,
  // Interrupts
  output logic [5:0]       o_chan_irq,
  output logic             o_irq
);
  tim_chan_pkg::state_t s_q;
  tim_chan_pkg::state_t s_d;
  logic [5:0]           cap_ev;
  logic [5:0]           match;
  logic [5:0]           ev;
  logic [5:0]           dis;
  logic [5:0]           oc;
  logic [5:0]           act;
  logic                 take;
  logic                 rd_take;
  logic [2:0]           rch;
  logic [2:0]           wch;
  logic [1:0]           wra;
  logic [1:0]           rra;
  logic [7:0]           wb;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d     = s_q;
    take    = i_hsel && i_hready && (i_htrans == `HTRANS_NSQ) && (i_hsize == `HSIZE_WORD);
    rd_take = take && !i_hwrite;
    rch     = i_haddr[6:4];
    rra     = i_haddr[3:2];
    wch     = s_q.addr[6:4];
    wra     = s_q.addr[3:2];
    wb      = i_hwdata[7:0];
    cap_ev  = '0;
    match   = '0;
    ev      = '0;
    dis     = '0;
    oc      = '0;
    act     = '0;
    // Address phase is captured here, data is used one cycle later
    s_d.sel = take;
    s_d.wr  = i_hwrite;
    s_d.addr = i_haddr[7:0];
    for (int i = 0; i < `NCH; i++) begin
      // Even channels index themselves so no index ever leaves the array
      dis[i] = (i % 2 == 1) && s_q.ch[i - (i % 2)].msb;
      oc[i]  = s_q.ch[i].msb || s_q.ch[i].msa;
      act[i] = (s_q.ch[i].els != `ELS_OFF) && !dis[i];
      unique case (s_q.ch[i].els)
        `ELS_RISE: cap_ev[i] = i_pin_in[i] && !s_q.ch[i].pin_prev;
        `ELS_FALL: cap_ev[i] = !i_pin_in[i] && s_q.ch[i].pin_prev;
        default:   cap_ev[i] = i_pin_in[i] != s_q.ch[i].pin_prev;
      endcase
      cap_ev[i] = cap_ev[i] && act[i] && !oc[i] && !s_q.ch[i].cap_blk;
      // Each channel compares the count against its own value register
      match[i]  = act[i] && oc[i] && !s_q.ch[i].cmp_blk && (i_count == s_q.ch[i].val);
      ev[i]     = cap_ev[i] || match[i];
      s_d.ch[i].pin_prev = i_pin_in[i];
      if (cap_ev[i]) begin
        s_d.ch[i].val = i_count;
      end
      if (ev[i]) begin
        s_d.ch[i].armed = 1'b0;
      end
      // Register writes, data phase
      if (s_q.sel && s_q.wr && (wch == 3'(i)) && !dis[i]) begin
        unique case (wra)
          `RA_SC: begin
            if (!wb[`B_FLAG] && s_q.ch[i].armed && !ev[i]) begin
              s_d.ch[i].flag = 1'b0;
            end
            s_d.ch[i].armed = 1'b0;
            s_d.ch[i].ie    = wb[`B_IE];
            s_d.ch[i].msb   = (i % 2 == 0) ? wb[`B_MSB] : 1'b0;
            s_d.ch[i].msa   = wb[`B_MSA];
            s_d.ch[i].els   = wb[`B_ELSB:`B_ELSA];
            s_d.ch[i].tov   = wb[`B_TOV];
            s_d.ch[i].fmax  = wb[`B_MAX];
          end
          `RA_HI: begin
            s_d.ch[i].val[15:8] = wb;
            s_d.ch[i].cmp_blk   = oc[i];
          end
          `RA_LO: begin
            s_d.ch[i].val[7:0] = wb;
            s_d.ch[i].cmp_blk  = 1'b0;
          end
          default: ;
        endcase
      end
      // Set wins over any clear in the same cycle
      if (ev[i]) begin
        s_d.ch[i].flag = 1'b1;
      end
      // Read side effects, address phase
      if (rd_take && (rch == 3'(i)) && !dis[i]) begin
        if ((rra == `RA_SC) && s_q.ch[i].flag && !ev[i]) begin
          s_d.ch[i].armed = 1'b1;
        end
        if ((rra == `RA_HI) && !oc[i]) begin
          s_d.ch[i].cap_blk = 1'b1;
        end
        if (rra == `RA_LO) begin
          s_d.ch[i].cap_blk = 1'b0;
        end
      end
      // Output compare pin action
      if (i_overflow) begin
        s_d.ch[i].max_eff = s_q.ch[i].fmax;
      end
      if (act[i] && oc[i]) begin
        if (s_q.ch[i].tov && i_overflow) begin
          s_d.ch[i].pin_q = !s_q.ch[i].pin_q;
        end else if (match[i]) begin
          unique case (s_q.ch[i].els)
            `ELS_RISE: s_d.ch[i].pin_q = !s_q.ch[i].pin_q;
            `ELS_FALL: s_d.ch[i].pin_q = 1'b0;
            default:   s_d.ch[i].pin_q = 1'b1;
          endcase
        end
        if (s_q.ch[i].tov && s_q.ch[i].max_eff) begin
          s_d.ch[i].pin_q = 1'b1;
        end
        s_d.ch[i].oe = 1'b1;
      end else if (act[i]) begin
        s_d.ch[i].pin_q = i_port_data[i];
        s_d.ch[i].oe    = 1'b0;
      end else begin
        s_d.ch[i].pin_q = i_port_data[i];
        s_d.ch[i].oe    = i_port_dir[i];
      end
      if (dis[i]) begin
        s_d.ch[i].flag    = 1'b0;
        s_d.ch[i].ie      = 1'b0;
        s_d.ch[i].msa     = 1'b0;
        s_d.ch[i].els     = `ELS_OFF;
        s_d.ch[i].tov     = 1'b0;
        s_d.ch[i].fmax    = 1'b0;
      end
      s_d.ch[i].irq_req = s_d.ch[i].flag && s_d.ch[i].ie;
    end
    // Sticky status, write one to clear, set wins
    if (s_q.sel && s_q.wr && (s_q.addr == `A_EVT)) begin
      s_d.evt = s_q.evt & ~i_hwdata[5:0];
    end
    if (s_q.sel && s_q.wr && (s_q.addr == `A_MSK)) begin
      s_d.mask = i_hwdata[5:0];
    end
    s_d.evt = s_d.evt | ev;
    s_d.irq = |(s_d.evt & s_d.mask);
    // Read data taken from next state so a just-written value reads back
    s_d.rdata = '0;
    if (rd_take) begin
      if (i_haddr[7:0] == `A_EVT) begin
        s_d.rdata = {26'h0, s_d.evt};
      end else if (i_haddr[7:0] == `A_MSK) begin
        s_d.rdata = {26'h0, s_d.mask};
      end else if ((rch <= `CH_LAST) && (i_haddr[7] == 1'b0)) begin
        for (int i = 0; i < `NCH; i++) begin
          if ((rch == 3'(i)) && !dis[i]) begin
            unique case (rra)
              `RA_SC: s_d.rdata = {24'h0, s_d.ch[i].flag, s_d.ch[i].ie, s_d.ch[i].msb,
                                   s_d.ch[i].msa, s_d.ch[i].els, s_d.ch[i].tov,
                                   s_d.ch[i].fmax};
              `RA_HI: s_d.rdata = {24'h0, s_d.ch[i].val[15:8]};
              `RA_LO: s_d.rdata = {24'h0, s_d.ch[i].val[7:0]};
              default: s_d.rdata = '0;
            endcase
          end
        end
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_comb begin
    o_hrdata    = s_q.rdata;
    o_hreadyout = 1'b1;
    o_hresp     = 1'b0;
    o_irq       = s_q.irq;
    for (int i = 0; i < `NCH; i++) begin
      o_pin_out[i]  = s_q.ch[i].pin_q;
      o_pin_oe[i]   = s_q.ch[i].oe;
      o_chan_irq[i] = s_q.ch[i].irq_req;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  for (genvar g = 0; g < `NCH; g++) begin : g_chk
    AST_CAP_SETS: assert property (cap_ev[g] |=> s_q.ch[g].flag &&
      (s_q.ch[g].val == $past(i_count))) else $error("capture missed");
    AST_CMP_SETS: assert property (match[g] |=> s_q.ch[g].flag && s_q.evt[g])
      else $error("compare flag missed");
    AST_CLR_SEQ: assert property (s_q.sel && s_q.wr && s_q.addr[6:4] == 3'(g) &&
      s_q.addr[3:2] == `RA_SC && !i_hwdata[`B_FLAG] && s_q.ch[g].armed && !ev[g]
      |=> !s_q.ch[g].flag) else $error("clear sequence failed");
    AST_NO_LOSS: assert property (s_q.ch[g].armed && ev[g] ##1 !ev[g]
      |-> s_q.ch[g].flag && !s_q.ch[g].armed) else $error("event lost");
    AST_W1_NOP: assert property (!s_q.ch[g].flag && !ev[g] |=> !s_q.ch[g].flag)
      else $error("flag set without event");
    AST_IRQ_REQ: assert property (o_chan_irq[g] == (s_q.ch[g].flag && s_q.ch[g].ie))
      else $error("channel request mismatch");
    AST_CAP_BLK: assert property (s_q.ch[g].cap_blk |-> !cap_ev[g])
      else $error("capture while blocked");
    AST_CMP_BLK: assert property (s_q.ch[g].cmp_blk |-> !match[g])
      else $error("compare while blocked");
    AST_OVF_WINS: assert property (act[g] && oc[g] && s_q.ch[g].tov && i_overflow &&
      !s_q.ch[g].max_eff |=> o_pin_out[g] != $past(o_pin_out[g])) else $error("no toggle");
    AST_FULL: assert property (act[g] && oc[g] && s_q.ch[g].tov && s_q.ch[g].max_eff
      |=> o_pin_out[g]) else $error("full duty not held");
  end
  for (genvar g = 1; g < `NCH; g += 2) begin : g_pair
    AST_ODD_OFF: assert property (s_q.ch[g-1].msb ##1 s_q.ch[g-1].msb
      |-> o_pin_oe[g] == $past(i_port_dir[g]) && !s_q.ch[g].flag) else $error("odd not freed");
  end
endmodule
`default_nettype wire

/* File: design/tim_chan_cfg.svh */
`ifndef TIM_CHAN_CFG_SVH
`define TIM_CHAN_CFG_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define NCH        6
`define RA_SC      2'h0
`define RA_HI      2'h1
`define RA_LO      2'h2
`define A_EVT      8'h60
`define A_MSK      8'h64
`define CH_LAST    3'h5
// ----------------------------------------
// Status/control fields
// ----------------------------------------
`define B_FLAG     7
`define B_IE       6
`define B_MSB      5
`define B_MSA      4
`define B_ELSB     3
`define B_ELSA     2
`define B_TOV      1
`define B_MAX      0
`define ELS_OFF    2'h0
`define ELS_RISE   2'h1
`define ELS_FALL   2'h2
`define HTRANS_NSQ 2'h2
`define HSIZE_WORD 3'h2
`endif

/* File: design/tim_chan_pkg.sv */
package tim_chan_pkg;
  typedef struct packed {
    logic        flag;
    logic        ie;
    logic        msb;
    logic        msa;
    logic [1:0]  els;
    logic        tov;
    logic        fmax;
    logic        max_eff;
    logic [15:0] val;
    logic        armed;
    logic        cap_blk;
    logic        cmp_blk;
    logic        pin_prev;
    logic        pin_q;
    logic        oe;
    logic        irq_req;
  } ch_t;

  typedef struct packed {
    ch_t [5:0]   ch;
    logic [5:0]  evt;
    logic [5:0]  mask;
    logic        irq;
    logic        sel;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] rdata;
  } state_t;
endpackage

/* File: tb/pin_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pin_model (
  // Clock
  input  wire logic       i_mclk,
  // Outside drivers
  input  wire logic [5:0] i_level,
  // Design pins
  input  wire logic [5:0] i_pin_out,
  input  wire logic [5:0] i_pin_oe,
  output logic      [5:0] o_pin
);
  // Driven pins read back; the rest follow the outside level, one flop late like a synchroniser
  always_ff @(posedge i_mclk) begin
    o_pin <= (i_pin_oe & i_pin_out) | (~i_pin_oe & i_level);
  end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`include "tim_chan_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic        clk, rstn, hsel, hwrite, ovf, hrdy, hr_s, hresp, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd_s, r;
  logic [15:0] cnt;
  logic [5:0]  lvl, pin, pout, poe, cirq, pdir;
  int          n_errors, num_checks;
  row_t        tbl [8];

  tim_chan i_tim_chan (.i_mclk(clk), .i_rstn(rstn), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp), .i_count(cnt), .i_overflow(ovf),
    .i_pin_in(pin), .i_port_data(pdir), .i_port_dir(pdir), .o_pin_out(pout), .o_pin_oe(poe),
    .o_chan_irq(cirq), .o_irq(irq));
  pin_model i_pin_model (.i_mclk(clk), .i_level(lvl), .i_pin_out(pout), .i_pin_oe(poe),
    .o_pin(pin));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Bus answers are latched mid-cycle so the edge that ends a phase never races them
  always @(negedge clk) begin
    rd_s <= hrdata;
    hr_s <= hrdy;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic results;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wt;
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hr_s !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_errors++;
      results();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= `HTRANS_NSQ;
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wt();
    r = rd_s;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(r, {24'h0, e});
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // One-cycle counter value and overflow pulse, then back to an idle count
  task automatic pulse(input logic [15:0] c, input logic o);
    cnt <= c;
    ovf <= o;
    @(posedge clk);
    cnt <= 16'h0;
    ovf <= 1'b0;
    settle();
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int k;
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = `HSIZE_WORD;
    hwdata = 32'h0;
    cnt = 16'h1234;
    ovf = 1'b0;
    lvl = 6'h00;
    pdir = 6'h02;
    n_errors = 0;
    num_checks = 0;
    tbl = '{
      '{8'h00, 8'hff, 8'h7f},
      '{8'h10, 8'h5c, 8'h00},
      '{8'h00, 8'h00, 8'h00},
      '{8'h10, 8'h5c, 8'h5c},
      '{8'h10, 8'h20, 8'h00},
      '{8'h24, 8'ha5, 8'ha5},
      '{8'h28, 8'h5a, 8'h5a},
      '{8'h70, 8'hff, 8'h00}};
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1 chk({25'h0, irq, cirq}, 32'h0);
    rdc(8'h00, 8'h00);
    foreach (tbl[i]) begin
      bus(1'b1, tbl[i].a, tbl[i].d);
      rdc(tbl[i].a, tbl[i].e);
    end
    bus(1'b1, 8'h00, 8'h20);
    settle();
    chk({26'h0, poe & pout}, 32'h2);
    bus(1'b1, 8'h00, 8'h00);
    // Capture on both edges; a late event must cancel the clear sequence so the flag survives
    bus(1'b1, 8'h30, 8'h4c);
    lvl <= 6'h08;
    for (k = 0; k < 50 && cirq[3] !== 1'b1; k++) @(posedge clk);
    chk({31'h0, cirq[3]}, 32'h1);
    if (k >= 50) results();
    chk({26'h0, poe}, 32'h2);
    rdc(8'h30, 8'hcc);
    lvl <= 6'h00;
    settle();
    bus(1'b1, 8'h30, 8'h4c);
    rdc(8'h30, 8'hcc);
    bus(1'b1, 8'h30, 8'h4c);
    rdc(8'h30, 8'h4c);
    chk({26'h0, cirq}, 32'h0);
    rdc(8'h34, 8'h12);
    cnt <= 16'h5678;
    lvl <= 6'h08;
    settle();
    rdc(8'h38, 8'h34);
    rdc(8'h34, 8'h12);
    // Compare on channel 4 with overflow toggling
    bus(1'b1, 8'h44, 8'h00);
    bus(1'b1, 8'h48, 8'h50);
    bus(1'b1, 8'h40, 8'h5e);
    bus(1'b1, 8'h44, 8'h12);
    pulse(16'h1250, 1'b0);
    rdc(8'h40, 8'h5e);
    bus(1'b1, 8'h48, 8'h50);
    pulse(16'h1250, 1'b0);
    chk({31'h0, pout[4]}, 32'h1);
    rdc(8'h40, 8'hde);
    pulse(16'h1250, 1'b1);
    chk({31'h0, pout[4]}, 32'h0);
    pulse(16'h0000, 1'b1);
    chk({31'h0, pout[4]}, 32'h1);
    // Summary interrupt: raise, mask, clear
    rdc(`A_EVT, 8'h18);
    bus(1'b1, `A_MSK, 8'h10);
    settle();
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, `A_MSK, 8'h00);
    settle();
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, `A_MSK, 8'h10);
    bus(1'b1, `A_EVT, 8'h18);
    settle();
    chk({31'h0, irq}, 32'h0);
    // Full duty: three overflows would leave a toggling pin low
    bus(1'b1, 8'h40, 8'h5f);
    repeat (3) pulse(16'h0000, 1'b1);
    chk({31'h0, pout[4]}, 32'h1);
    results();
  end
endmodule
`default_nettype wire
